// ---- rtl/quadrature_position_measurement_pkg.sv ----
/*
 Constants for the quadrature position measurement block: register indices,
 status and command codes, timing counts, the command state type and the
 bus decode and float helpers.
 Assumes a 100 MHz system clock and a word-per-register AHB-Lite map.
*/
package quadrature_position_measurement_pkg;

   // Clock and the front-end sampling time base
   localparam int CLK_HZ      = 100_000_000;
   localparam int TIMEBASE_HZ = 5_000_000;
   localparam int TB_DIV      = CLK_HZ / TIMEBASE_HZ;
   // Longest read answer allowed to the host, and its cycle count
   localparam int RESP_MAX_MS = 4;
   localparam int RESP_MAX_CYC = (CLK_HZ / 1000) * RESP_MAX_MS;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_RESERVED_0      = 6'h00;
   localparam logic [5:0] IDX_CHANNEL_STATUS  = 6'h01;
   localparam logic [5:0] IDX_IRQ_LEVEL       = 6'h02;
   localparam logic [5:0] IDX_IRQ_VECTOR      = 6'h03;
   localparam logic [5:0] IDX_SCALE_FACTOR    = 6'h04;
   localparam logic [5:0] IDX_CW_LIMIT_ANGLE  = 6'h08;
   localparam logic [5:0] IDX_CCW_LIMIT_ANGLE = 6'h0c;
   localparam logic [5:0] IDX_DIRECTION       = 6'h11;
   localparam logic [5:0] IDX_CURRENT_ANGLE   = 6'h14;
   localparam logic [5:0] IDX_COMMAND         = 6'h20;
   localparam logic [5:0] IDX_CHANNEL_ID      = 6'h21;
   localparam logic [5:0] IDX_COMMAND_STATUS  = 6'h22;
   localparam logic [5:0] IDX_MODE            = 6'h23;
   localparam int         MODE_CONT_BIT       = 0;

   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Channel status codes
   localparam logic [7:0] ST_NONE    = 8'h00;
   localparam logic [7:0] ST_CW_OVF  = 8'h01;
   localparam logic [7:0] ST_CCW_OVF = 8'h02;
   localparam logic [7:0] ST_CW_LIM  = 8'h03;
   localparam logic [7:0] ST_CCW_LIM = 8'h04;
   localparam logic [7:0] ST_READY   = 8'h10;

   // Commands and command status codes
   localparam logic [7:0] CMD_START      = 8'h13;
   localparam logic [7:0] CMD_READ       = 8'h15;
   localparam logic [7:0] CS_PENDING     = 8'h00;
   localparam logic [7:0] CS_ACK         = 8'h01;
   localparam logic [7:0] CS_ALLOC_ERR   = 8'h02;
   localparam logic [7:0] CS_BAD_CMD     = 8'h03;

   // Direction indicator values
   localparam logic [7:0] DIR_CW  = 8'hff;
   localparam logic [7:0] DIR_CCW = 8'h00;

   // Cycles from a count change to a fresh angle
   localparam logic [1:0] PIPE_LAT = 2'd3;

   // Float constants
   localparam logic [7:0] FLT_BIAS = 8'd127;
   localparam logic [7:0] FLT_EMAX = 8'hff;

   function automatic logic wr_hit(input logic w, input logic [5:0] a,
                                   input logic [5:0] idx);
      return w && (a == idx);
   endfunction

   // Signed count to float, truncating the low mantissa bits
   function automatic logic [31:0] int_to_float(input logic [31:0] v);
      logic        s;
      logic [31:0] m;
      logic [4:0]  p;
      logic [31:0] n;
      s = v[31];
      m = s ? (32'h0 - v) : v;
      p = 5'd0;
      for (int i = 0; i < 32; i++) begin
         if (m[i]) begin
            p = 5'(i);
         end
      end
      n = m << (5'd31 - p);
      if (m == 32'h0) begin
         return RST_WORD;
      end
      return {s, FLT_BIAS + {3'h0, p}, n[30:8]};
   endfunction

   // Float multiply; denormals flush to zero, overflow saturates to infinity
   function automatic logic [31:0] fmul(input logic [31:0] a,
                                        input logic [31:0] b);
      logic        s;
      logic [47:0] pr;
      logic [9:0]  e;
      logic [22:0] mt;
      s  = a[31] ^ b[31];
      pr = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e  = {2'h0, a[30:23]} + {2'h0, b[30:23]} - {2'h0, FLT_BIAS}
           + {9'h0, pr[47]};
      mt = pr[47] ? pr[46:24] : pr[45:23];
      if (a[30:23] == 8'h0 || b[30:23] == 8'h0 || e[9] || e == 10'h0) begin
         return RST_WORD;
      end
      if (e >= {2'h0, FLT_EMAX}) begin
         return {s, FLT_EMAX, 23'h0};
      end
      return {s, e[7:0], mt};
   endfunction

   typedef enum {CMD_IDLE, CMD_DECODE, CMD_WAIT} cmd_state_t;

endpackage

// ---- rtl/quadrature_front_end.sv ----
/*
 Quadrature front end: samples the two encoder inputs on each time base
 tick and turns each edge on one line alone into one clockwise or counterclockwise pulse.
 Assumes inputs are synchronous to i_mclk and i_tick is one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module quadrature_front_end (
   input  wire logic i_mclk,      // System clock
   input  wire logic i_nrst,      // Synchronous reset, active low
   input  wire logic i_tick,      // Time base sample strobe
   input  wire logic i_even,      // Clockwise encoder signal
   input  wire logic i_odd,       // Counterclockwise encoder signal
   output logic      o_cw_pulse,  // One clockwise step
   output logic      o_ccw_pulse, // One counterclockwise step
   output logic      o_dir_cw     // Last motion was clockwise
);
   logic [1:0] prev;
   logic [1:0] cur;

   assign cur = {i_even, i_odd};

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         prev        <= 2'h0;
         o_cw_pulse  <= 1'b0;
         o_ccw_pulse <= 1'b0;
         o_dir_cw    <= 1'b1;
      end else begin
         o_cw_pulse  <= 1'b0;
         o_ccw_pulse <= 1'b0;
         if (i_tick) begin
            prev <= cur;
            unique case ({prev, cur})
               4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: begin
                  o_cw_pulse <= 1'b1;
                  o_dir_cw   <= 1'b1;
               end
               4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: begin
                  o_ccw_pulse <= 1'b1;
                  o_dir_cw    <= 1'b0;
               end
               // No change, or both changed at once: not countable
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/quadrature_position_measurement.sv ----
/*
 Quadrature position measurement for one even/odd channel pair, with its
 channel control block reached as an AHB-Lite slave (zero wait states).
 Assumes one master doing single word transfers with an idle between them.
*/
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module quadrature_position_measurement
   import quadrature_position_measurement_pkg::*;
(
   input  wire logic        i_mclk,          // 100 MHz clock
   input  wire logic        i_nrst,          // Synchronous reset, active low
   input  wire logic        i_hsel,          // AHB slave select
   input  wire logic [7:0]  i_haddr,         // AHB byte address
   input  wire logic [1:0]  i_htrans,        // AHB transfer type
   input  wire logic        i_hwrite,        // AHB write
   input  wire logic [2:0]  i_hsize,         // AHB size, word only
   input  wire logic [31:0] i_hwdata,        // AHB write data
   input  wire logic        i_hready,        // AHB bus ready
   output logic [31:0]      o_hrdata,        // AHB read data
   output logic             o_hreadyout,     // AHB slave ready
   output logic             o_hresp,         // AHB response
   input  wire logic        i_enc_even,      // Clockwise encoder input
   input  wire logic        i_enc_odd,       // Counterclockwise encoder input
   output logic             o_irq_pulse,     // Alarm interrupt request
   output logic [7:0]       o_irq_level,     // Configured interrupt level
   output logic [7:0]       o_irq_vector,    // Configured interrupt vector
   output logic             o_queue_valid,   // Alarm message queue write
   output logic [7:0]       o_queue_channel  // Channel number of the alarm
);

   logic [7:0]  qpm_channel_status;
   logic [31:0] qpm_scale_factor;
   logic [31:0] qpm_cw_limit_angle;
   logic [31:0] qpm_ccw_limit_angle;
   logic [7:0]  qpm_direction_indicator;
   logic [31:0] qpm_current_angle;
   logic [7:0]  command;
   logic [7:0]  channel_id;
   logic [7:0]  command_status;
   logic        mode_cont;
   logic        wr_q;
   logic [5:0]  addr_q;
   logic        cmd_go;
   logic        running;
   logic [4:0]  tb_cnt;
   logic        tick;
   logic        cw_pulse;
   logic        ccw_pulse;
   logic        dir_cw;
   logic [1:0]  pulse;
   logic [15:0] cnt_lo [2];
   logic [15:0] cnt_hi [2];
   logic [31:0] inc [2];
   logic [31:0] next_cnt [2];
   logic [1:0]  ovf;
   logic [31:0] diff;
   logic [31:0] diff_flt;
   logic [31:0] angle;
   logic        cw_viol;
   logic        ccw_viol;
   logic        cw_viol_q;
   logic        ccw_viol_q;
   logic        alarm_evt;
   logic [7:0]  alarm_code;
   logic        alarm_pending;
   logic        start_pulse;
   logic        read_done;
   logic [1:0]  wait_cnt;
   cmd_state_t  state;
   logic [31:0] rd_mux;

   // Zero wait states; every transfer is answered OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         wr_q   <= 1'b0;
         addr_q <= 6'h0;
      end else begin
         wr_q   <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
         addr_q <= i_haddr[7:2];
      end
   end
   always_comb begin
      unique case (i_haddr[7:2])
         IDX_CHANNEL_STATUS:  rd_mux = {24'h0, qpm_channel_status};
         IDX_IRQ_LEVEL:       rd_mux = {24'h0, o_irq_level};
         IDX_IRQ_VECTOR:      rd_mux = {24'h0, o_irq_vector};
         IDX_SCALE_FACTOR:    rd_mux = qpm_scale_factor;
         IDX_CW_LIMIT_ANGLE:  rd_mux = qpm_cw_limit_angle;
         IDX_CCW_LIMIT_ANGLE: rd_mux = qpm_ccw_limit_angle;
         IDX_DIRECTION:       rd_mux = {24'h0, qpm_direction_indicator};
         IDX_CURRENT_ANGLE:   rd_mux = qpm_current_angle;
         IDX_COMMAND:         rd_mux = {24'h0, command};
         IDX_CHANNEL_ID:      rd_mux = {24'h0, channel_id};
         IDX_COMMAND_STATUS:  rd_mux = {24'h0, command_status};
         IDX_MODE:            rd_mux = {31'h0, mode_cont};
         default:             rd_mux = RST_WORD;
      endcase
   end
   // Read data is latched in the address phase, so it stands all data phase
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_hrdata <= RST_WORD;
      end else if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
         o_hrdata <= rd_mux;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_irq_level         <= RST_BYTE;
         o_irq_vector        <= RST_BYTE;
         qpm_scale_factor    <= RST_WORD;
         qpm_cw_limit_angle  <= RST_WORD;
         qpm_ccw_limit_angle <= RST_WORD;
         channel_id          <= RST_BYTE;
         mode_cont           <= 1'b0;
      end else begin
         if (wr_hit(wr_q, addr_q, IDX_IRQ_LEVEL)) begin
            o_irq_level <= i_hwdata[7:0];
         end
         if (wr_hit(wr_q, addr_q, IDX_IRQ_VECTOR)) begin
            o_irq_vector <= i_hwdata[7:0];
         end
         if (wr_hit(wr_q, addr_q, IDX_SCALE_FACTOR)) begin
            qpm_scale_factor <= i_hwdata;
         end
         if (wr_hit(wr_q, addr_q, IDX_CW_LIMIT_ANGLE)) begin
            qpm_cw_limit_angle <= i_hwdata;
         end
         if (wr_hit(wr_q, addr_q, IDX_CCW_LIMIT_ANGLE)) begin
            qpm_ccw_limit_angle <= i_hwdata;
         end
         if (wr_hit(wr_q, addr_q, IDX_CHANNEL_ID)) begin
            channel_id <= i_hwdata[7:0];
         end
         if (wr_hit(wr_q, addr_q, IDX_MODE)) begin
            mode_cont <= i_hwdata[MODE_CONT_BIT];
         end
      end
   end
   // Time base tick, one cycle in every TB_DIV
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || tb_cnt == 5'(TB_DIV - 1)) begin
         tb_cnt <= 5'h0;
      end else begin
         tb_cnt <= tb_cnt + 5'h1;
      end
   end
   assign tick = (tb_cnt == 5'(TB_DIV - 1));
   quadrature_front_end u_front_end (
      .i_mclk      (i_mclk),
      .i_nrst      (i_nrst),
      .i_tick      (tick),
      .i_even      (i_enc_even),
      .i_odd       (i_enc_odd),
      .o_cw_pulse  (cw_pulse),
      .o_ccw_pulse (ccw_pulse),
      .o_dir_cw    (dir_cw)
   );
   assign pulse = {ccw_pulse, cw_pulse};
   always_comb begin
      for (int d = 0; d < 2; d++) begin
         inc[d] = {cnt_hi[d], cnt_lo[d]} + {31'h0, pulse[d]};
         ovf[d] = pulse[d] && ({cnt_hi[d], cnt_lo[d]} == 32'hffff_ffff);
         next_cnt[d] = inc[d];
      end
      if (inc[0] != 32'h0 && inc[1] != 32'h0) begin
         if (inc[0] >= inc[1]) begin
            next_cnt[0] = inc[0] - inc[1];
            next_cnt[1] = 32'h0;
         end else begin
            next_cnt[1] = inc[1] - inc[0];
            next_cnt[0] = 32'h0;
         end
      end
   end
   // Low half is the hardware counter, high half its extension
   for (genvar g = 0; g < 2; g++) begin : g_count
      always_ff @(posedge i_mclk) begin
         if (!i_nrst || start_pulse || !running) begin
            cnt_lo[g] <= 16'h0;
            cnt_hi[g] <= 16'h0;
         end else begin
            cnt_lo[g] <= next_cnt[g][15:0];
            cnt_hi[g] <= next_cnt[g][31:16];
         end
      end
   end
   assign diff = {cnt_hi[0], cnt_lo[0]} - {cnt_hi[1], cnt_lo[1]};
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || start_pulse) begin
         diff_flt <= RST_WORD;
         angle    <= RST_WORD;
      end else begin
         diff_flt <= int_to_float(diff);
         angle    <= fmul(diff_flt, qpm_scale_factor);
      end
   end
   // limits compared as magnitudes; the counterclockwise limit is a
   // positive angle measured in the counterclockwise sense
   assign cw_viol  = running && !angle[31] &&
                     (angle[30:0] > qpm_cw_limit_angle[30:0]);
   assign ccw_viol = running && angle[31] &&
                     (angle[30:0] > qpm_ccw_limit_angle[30:0]);
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         cw_viol_q  <= 1'b0;
         ccw_viol_q <= 1'b0;
      end else begin
         cw_viol_q  <= cw_viol;
         ccw_viol_q <= ccw_viol;
      end
   end
   always_comb begin
      alarm_evt  = 1'b1;
      alarm_code = ST_NONE;
      if (running && ovf[0]) begin
         alarm_code = ST_CW_OVF;
      end else if (running && ovf[1]) begin
         alarm_code = ST_CCW_OVF;
      end else if (cw_viol && !cw_viol_q) begin
         alarm_code = ST_CW_LIM;
      end else if (ccw_viol && !ccw_viol_q) begin
         alarm_code = ST_CCW_LIM;
      end else begin
         alarm_evt = 1'b0;
      end
   end
   assign alarm_pending = (qpm_channel_status >= ST_CW_OVF) &&
                          (qpm_channel_status <= ST_CCW_LIM);
   // alarm blocks ready; a new event wins over the host clear
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         qpm_channel_status <= ST_NONE;
      end else if (alarm_evt) begin
         qpm_channel_status <= alarm_code;
      end else if (read_done && !alarm_pending) begin
         qpm_channel_status <= ST_READY;
      end else if (wr_hit(wr_q, addr_q, IDX_CHANNEL_STATUS)) begin
         qpm_channel_status <= i_hwdata[7:0];
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_irq_pulse     <= 1'b0;
         o_queue_valid   <= 1'b0;
         o_queue_channel <= RST_BYTE;
      end else begin
         o_irq_pulse   <= alarm_evt && (o_irq_level != 8'h0);
         o_queue_valid <= alarm_evt && (o_irq_level == 8'h0);
         if (alarm_evt) begin
            o_queue_channel <= channel_id;
         end
      end
   end
   // A new command write wins over the decoder taking the last one
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         command <= RST_BYTE;
         cmd_go  <= 1'b0;
      end else if (wr_hit(wr_q, addr_q, IDX_COMMAND)) begin
         command <= i_hwdata[7:0];
         cmd_go  <= 1'b1;
      end else if (state == CMD_IDLE) begin
         cmd_go  <= 1'b0;
      end
   end
   assign start_pulse = (state == CMD_DECODE) && (command == CMD_START) &&
                        !channel_id[0];
   assign read_done   = (state == CMD_WAIT) && (wait_cnt == 2'h0);
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         state          <= CMD_IDLE;
         wait_cnt       <= 2'h0;
         running        <= 1'b0;
         command_status <= CS_PENDING;
      end else begin
         unique case (state)
            CMD_IDLE: begin
               if (cmd_go) begin
                  state          <= CMD_DECODE;
                  command_status <= CS_PENDING;
               end
            end
            CMD_DECODE: begin
               state <= CMD_IDLE;
               if (command == CMD_START) begin
                  if (!channel_id[0]) begin
                     running        <= 1'b1;
                     command_status <= CS_ACK;
                  end else begin
                     command_status <= CS_ALLOC_ERR;
                  end
               end else if (command == CMD_READ) begin
                  if (running) begin
                     state    <= CMD_WAIT;
                     wait_cnt <= PIPE_LAT - 2'h1;
                  end else begin
                     command_status <= CS_ALLOC_ERR;
                  end
               end else begin
                  command_status <= CS_BAD_CMD;
               end
            end
            CMD_WAIT: begin
               // Waits for an angle taken from counts seen after the command
               if (wait_cnt == 2'h0) begin
                  state          <= CMD_IDLE;
                  command_status <= CS_ACK;
               end else begin
                  wait_cnt <= wait_cnt - 2'h1;
               end
            end
         endcase
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         qpm_current_angle       <= RST_WORD;
         qpm_direction_indicator <= DIR_CCW;
      end else if (read_done || (mode_cont && running)) begin
         qpm_current_angle       <= angle;
         qpm_direction_indicator <= dir_cw ? DIR_CW : DIR_CCW;
      end
   end
endmodule
`default_nettype wire

// ---- tb/qpm_checker.sv ----
/* Assertions on the position block's bus and alarm outputs.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module qpm_checker (
   input wire logic        i_mclk, i_nrst, i_hsel, i_hwrite, i_hready,
   input wire logic [7:0]  i_haddr, o_irq_level,
   input wire logic [1:0]  i_htrans,
   input wire logic [31:0] i_hwdata,
   input wire logic        o_hreadyout, o_hresp, o_irq_pulse, o_queue_valid
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   wire logic lvl_wr = i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr == 8'h08;
   bus_okay_a: assert property (o_hreadyout && !o_hresp)
      else $error("bus slave not ready or not okay");
   notify_excl_a: assert property (!(o_irq_pulse && o_queue_valid))
      else $error("alarm sent both ways");
   irq_level_a: assert property (o_irq_pulse |-> o_irq_level != 8'h00)
      else $error("interrupt with level zero");
   queue_level_a: assert property (o_queue_valid |-> o_irq_level == 8'h00)
      else $error("queue entry while interrupt level set");
   irq_once_a: assert property (o_irq_pulse |=> !o_irq_pulse)
      else $error("interrupt longer than one cycle");
   queue_once_a: assert property (o_queue_valid |=> !o_queue_valid)
      else $error("queue write longer than one cycle");
   level_write_a: assert property (lvl_wr ##1 1 |=> o_irq_level == $past(i_hwdata[7:0]))
      else $error("level register not written");
   reset_quiet_a: assert property ($rose(i_nrst) |-> !o_irq_pulse && !o_queue_valid)
      else $error("alarm right after reset");
   cover property (o_irq_pulse);
   cover property (o_queue_valid);
   cover property (lvl_wr);
endmodule
bind quadrature_position_measurement qpm_checker chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
   .i_hsel(i_hsel), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_haddr(i_haddr),
   .o_irq_level(o_irq_level), .i_htrans(i_htrans), .i_hwdata(i_hwdata),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq_pulse(o_irq_pulse),
   .o_queue_valid(o_queue_valid));
`default_nettype wire

// ---- tb/quadrature_encoder_model.sv ----
/* Quadrature encoder model: steps a gray-coded line pair on request.
   Driven by the bench just after rising clock edges. */
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_model (
   input wire logic       i_mclk,  // System clock
   input wire logic       i_nrst,  // Reset, active low
   input wire logic       i_start, // Load a step count
   input wire logic       i_cw,    // Step direction
   input wire logic [7:0] i_count, // Steps to make
   output logic           o_even,  // Clockwise line
   output logic           o_odd,   // Counterclockwise line
   output logic           o_busy   // Steps remain
);
   logic [7:0] left;
   logic [4:0] gap;
   logic [1:0] ph;
   assign o_even = ph[1] ^ ph[0];
   assign o_odd = ph[1];
   assign o_busy = left != 8'h00;
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         ph <= 2'h0;
         left <= 8'h00;
         gap <= 5'h00;
      end else if (i_start) begin
         left <= i_count;
      end else if (o_busy) begin
         gap <= gap + 5'h01;
         if (gap == 5'h17) begin
            gap <= 5'h00;
            left <= left - 8'h01;
            ph <= i_cw ? ph + 2'h1 : ph - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_quadrature_position_measurement.sv ----
/* Bench for the position block: AHB master tasks, encoder model and
   random moves. Assumes a zero wait state slave with idles between. */
`timescale 1ns/1ps
`default_nettype none
module tb_quadrature_position_measurement;
   import quadrature_position_measurement_pkg::*;
   logic        mclk = '0, nrst = '0, hsel = '0, hwrite = '0, go = '0, cw = '0;
   logic [7:0]  haddr = '0, cnt = '0, lvl, qch, vec;
   logic [1:0]  htrans = '0;
   logic [31:0] hwdata = '0, hrdata, x = 32'h56, v;
   logic        hready, hresp, irq, qv, even, odd, busy;
   logic [7:0]  ra[8] = '{8'h04, 8'h08, 8'h0c, 8'h44, 8'h50, 8'h88, 8'h40, 8'h00};
   int          miscompares = 0, cmp_count = 0, n_irq = 0, n_q = 0, pos = 0, shown = 0, q0 = 0;
   quadrature_position_measurement uut (.i_mclk(mclk), .i_nrst(nrst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .i_enc_even(even), .i_enc_odd(odd), .o_irq_pulse(irq),
      .o_irq_level(lvl), .o_irq_vector(vec), .o_queue_valid(qv), .o_queue_channel(qch));
   quadrature_encoder_model enc (.i_mclk(mclk), .i_nrst(nrst), .i_start(go), .i_cw(cw),
      .i_count(cnt), .o_even(even), .o_odd(odd), .o_busy(busy));
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (irq === 1'b1) n_irq++;
      if (qv === 1'b1) n_q++;
   end
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic logic [31:0] flt(input int n);
      int m;
      int e;
      if (n == 0) return 32'h0;
      m = n < 0 ? -n : n;
      e = 0;
      while ((m >> e) > 1) e++;
      return {n < 0, 8'(127 + e), 23'(m << (23 - e))};
   endfunction
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmpv(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      cmpv($sformatf("reg %h", a), e, hrdata);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] e);
      bus(1'b1, 8'h80, {24'h0, c});
      repeat (8) @(posedge mclk);
      rd(8'h88, {24'h0, e});
   endtask
   task automatic move(input logic d, input logic [7:0] n);
      @(posedge mclk);
      cw <= d;
      cnt <= n;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      do @(posedge mclk); while (busy === 1'b1);
      // Front end samples every 20 clocks, then the angle pipeline
      repeat (40) @(posedge mclk);
      pos = d ? pos + int'(n) : pos - int'(n);
   endtask
   task automatic cfg(input logic [31:0] cwl, input logic [31:0] ccwl, input logic [7:0] l);
      bus(1'b1, 8'h04, '0);
      bus(1'b1, 8'h08, {24'h0, l});
      bus(1'b1, 8'h10, flt(1));
      bus(1'b1, 8'h20, cwl);
      bus(1'b1, 8'h30, ccwl);
      bus(1'b1, 8'h84, '0);
      cmd(CMD_START, CS_ACK); // even channel started
      pos = 0;
      shown = 0;
      cmd(CMD_READ, CS_ACK); // fresh angle after start
      rd(8'h50, '0); // position from zero
   endtask
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      foreach (ra[i]) rd(ra[i], '0); // cleared and unmapped places
      cmd(CMD_READ, CS_ALLOC_ERR); // read before start
      bus(1'b1, 8'h84, 32'h1);
      cmd(CMD_START, CS_ALLOC_ERR); // odd channel refused
      bus(1'b1, 8'h44, 32'hffff_ffff);
      rd(8'h44, '0); // direction read only
      v = rnd();
      bus(1'b1, 8'h0c, v);
      rd(8'h0c, {24'h0, v[7:0]}); // vector byte kept
      cmpv("irq vector", {24'h0, v[7:0]}, {24'h0, vec}); // vector output
      cfg(flt(1000), flt(1000), 8'h00);
      for (int i = 0; i < 5; i++) begin
         v = rnd();
         move(v[0], {5'h0, v[10:8]} + 8'h01);
         rd(8'h50, flt(shown)); // no update without read
         cmd(CMD_READ, CS_ACK);
         shown = pos;
         rd(8'h50, flt(pos)); // scaled difference
         rd(8'h44, v[0] ? {24'h0, DIR_CW} : {24'h0, DIR_CCW}); // direction byte
         rd(8'h04, {24'h0, ST_READY}); // ready status
      end
      cmpv("alarm count", '0, n_irq + n_q); // no position events
      cfg(flt(2), flt(1000), 8'h00);
      // Writing a lower limit while still running may raise an early alarm
      q0 = n_q;
      move(1'b1, 8'h03);
      rd(8'h04, {24'h0, ST_CW_LIM}); // clockwise limit code
      cmpv("queue count", 32'h1, n_q - q0); // queue without level
      cmpv("queue channel", '0, {24'h0, qch}); // even channel number
      cmd(CMD_READ, CS_ACK);
      rd(8'h04, {24'h0, ST_CW_LIM}); // ready held back
      rd(8'h50, flt(3)); // position kept during alarm
      bus(1'b1, 8'h04, '0);
      cmd(CMD_READ, CS_ACK);
      rd(8'h04, {24'h0, ST_READY}); // ready after clear
      cfg(flt(1000), flt(1), 8'h05);
      move(1'b0, 8'h02);
      rd(8'h04, {24'h0, ST_CCW_LIM}); // counterclockwise limit code
      cmpv("irq count", 32'h1, n_irq); // interrupt with level
      cmpv("irq level", 32'h5, {24'h0, lvl}); // level stands
      bus(1'b1, 8'h8c, 32'h1);
      move(1'b1, 8'h05);
      rd(8'h50, flt(3)); // continuous angle
      rd(8'h44, {24'h0, DIR_CW}); // clockwise byte
      complete_run();
   end
endmodule
`default_nettype wire
